// ---- common/ehbp_defines.svh ----
// Address map, reset values and timing counts of the host bus port
`ifndef EHBP_DEFINES_SVH
`define EHBP_DEFINES_SVH

`define EHBP_ADDR_PKT_ERR 8'h39
`define EHBP_ADDR_EP4_PLD 8'h6C
`define EHBP_ADDR_EP5_PLD 8'h6D
`define EHBP_ADDR_EP4_RXC 8'h74
`define EHBP_ADDR_EP5_RXC 8'h75
`define EHBP_ADDR_FIFO_CLR 8'h4E
`define EHBP_ADDR_FIFO 8'h40

`define EHBP_EP4_BITS 2
`define EHBP_EP5_BITS 1
`define EHBP_RESET_BYTE 8'h00

`define EHBP_ERR_PID 0
`define EHBP_ERR_STUFF 1
`define EHBP_ERR_DCRC 2
`define EHBP_ERR_ACRC 3

`define EHBP_CLK_NS 50
`define EHBP_REREQ_NS 63
`define EHBP_REREQ_CYC (((`EHBP_REREQ_NS / `EHBP_CLK_NS) < 1) ? 1 : \
    (`EHBP_REREQ_NS / `EHBP_CLK_NS))

`endif

// ---- common/ehbp_pkg.sv ----
// Types shared by the host bus port
`default_nettype none
package ehbp_pkg;

    // Error events of one received packet
    typedef struct packed {
        logic addr_crc;
        logic data_crc;
        logic bit_stuff;
        logic pid;
    } ehbp_err_t;

    // Static DMA configuration
    typedef struct packed {
        logic enable;
        logic single_addr;
        logic demand;
        logic [7:0] interval;
    } ehbp_dma_cfg_t;

    // DMA request sequencer states
    typedef enum logic [2:0] {
        EHBP_DMA_IDLE = 3'b001,
        EHBP_DMA_REQ = 3'b010,
        EHBP_DMA_GAP = 3'b100
    } ehbp_dma_st_t;

endpackage
`default_nettype wire

// ---- hdl/ehbp_rst_sync.sv ----
// Two-stage release synchroniser for the active-low reset
`default_nettype none
module ehbp_rst_sync (
    input wire logic clk_in,
    input wire logic nrst_in,
    output logic nrst_out
);
    logic meta_ff;
    logic hold_ff;

    // Assert at once, release after two edges
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            meta_ff <= 1'b0;
            hold_ff <= 1'b0;
        end else begin
            meta_ff <= 1'b1;
            hold_ff <= meta_ff;
        end
    end

    assign nrst_out = hold_ff;
endmodule
`default_nettype wire

// ---- hdl/ehbp_port.sv ----
// Host bus port: payload and count MSB registers, packet errors, DMA pacing
//
// Function
// - Endpoint four and five payload MSB registers are read/write with 2 and 1 live bits.
// - Receive count MSB registers are read-only with 2 and 1 live bits, upper bits zero.
// - Packet error flags for PID, bit stuff, data CRC and address CRC set on detection.
// - All packet error flags clear when the next start of packet arrives, except a flag whose error is detected in that same cycle.
// - The format select input picks separate or multiplexed address and data lines.
// - Single-address DMA ignores chip select and address, using acknowledge and strobe.
// - The request interval setting lengthens the re-request delay.
// - Dual-address DMA ignores acknowledge and uses chip select with the FIFO address.
// - Demand DMA holds the request across transfers until the FIFO has no more data.
`include "ehbp_defines.svh"
`default_nettype none
module ehbp_port (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic usb_reset_in,
    input wire logic bus_format_select_in,
    input wire logic cs_n_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] dq_in,
    output logic [7:0] dq_out,
    output logic dq_oe_out,
    input wire ehbp_pkg::ehbp_err_t pkt_err_in,
    input wire logic sop_in,
    input wire logic ep4_rx_load_in,
    input wire logic [1:0] ep4_rx_count_in,
    input wire logic ep5_rx_load_in,
    input wire logic ep5_rx_count_in,
    output logic [1:0] ep4_payload_size_high_out,
    output logic ep5_payload_size_high_out,
    input wire logic [7:0] fifo_rdata_in,
    input wire logic fifo_has_data_in,
    output logic fifo_rd_step_out,
    output logic fifo_wr_step_out,
    output logic [7:0] fifo_wdata_out,
    output logic fifo_clear_out,
    input wire ehbp_pkg::ehbp_dma_cfg_t dma_cfg_in,
    input wire logic dma_acknowledge_n_in,
    output logic dma_request_out
);
    localparam int CNT_W = 9;
    localparam logic [CNT_W-1:0] REREQ_CYC = CNT_W'(`EHBP_REREQ_CYC);

    // Refuse widths and delays that the registers and the gap counter cannot hold
    if (`EHBP_EP4_BITS != 2 || `EHBP_EP5_BITS != 1 || `EHBP_REREQ_CYC < 1
        || `EHBP_REREQ_CYC > 256) begin : g_bad_cfg
        $error("ehbp_port: unsupported register width or delay");
    end

    logic rst_n;
    ehbp_rst_sync u_rst (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .nrst_out(rst_n)
    );

    // Registers
    logic [1:0] pld4_ff;
    logic pld5_ff;
    logic [1:0] rxc4_ff;
    logic rxc5_ff;
    ehbp_pkg::ehbp_err_t err_ff;
    logic cs_prev_ff;
    logic [7:0] addr_lat_ff;
    logic acc_ff;
    logic acc_wr_ff;
    logic acc_dma_ff;
    logic [7:0] acc_addr_ff;
    logic [7:0] wdata_ff;
    logic [7:0] rdata_ff;
    ehbp_pkg::ehbp_dma_st_t dma_st_ff;
    ehbp_pkg::ehbp_dma_st_t nxt_dma_st;
    logic [CNT_W-1:0] gap_cnt_ff;
    logic [CNT_W-1:0] nxt_gap_cnt;

    // Access decode
    wire rd_act = !rd_n_in;
    wire wr_act = !wr_n_in;
    wire cs_act = !cs_n_in;
    wire cs_start = cs_act && !cs_prev_ff;
    wire dma_single_sel = dma_cfg_in.enable && dma_cfg_in.single_addr
        && !dma_acknowledge_n_in;
    wire sel = dma_single_sel || cs_act;
    wire acc_on = sel && (rd_act || wr_act);
    wire [7:0] mux_addr = cs_start ? dq_in : addr_lat_ff;
    wire [7:0] pin_addr = bus_format_select_in ? mux_addr : addr_in;
    wire [7:0] eff_addr = dma_single_sel ? `EHBP_ADDR_FIFO : pin_addr;
    wire is_fifo = (eff_addr == `EHBP_ADDR_FIFO);
    wire dual_dma = dma_cfg_in.enable && !dma_cfg_in.single_addr && cs_act
        && is_fifo;
    wire done = acc_ff && !acc_on;
    wire done_fifo = done && (acc_addr_ff == `EHBP_ADDR_FIFO);
    wire dma_done = done && acc_dma_ff;
    wire wr_commit = done && acc_wr_ff;
    wire more_data = dma_cfg_in.enable && fifo_has_data_in;

    // Read data selection
    logic [7:0] rd_mux;
    always_comb begin
        case (eff_addr)
            `EHBP_ADDR_PKT_ERR: rd_mux = {4'h0, err_ff};
            `EHBP_ADDR_EP4_PLD: rd_mux = {6'h00, pld4_ff};
            `EHBP_ADDR_EP5_PLD: rd_mux = {7'h00, pld5_ff};
            `EHBP_ADDR_EP4_RXC: rd_mux = {6'h00, rxc4_ff};
            `EHBP_ADDR_EP5_RXC: rd_mux = {7'h00, rxc5_ff};
            `EHBP_ADDR_FIFO: rd_mux = fifo_rdata_in;
            default: rd_mux = `EHBP_RESET_BYTE;
        endcase
    end

    // Bus access tracking and multiplexed address latch
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            cs_prev_ff <= 1'b0;
            addr_lat_ff <= 8'h00;
            acc_ff <= 1'b0;
            acc_wr_ff <= 1'b0;
            acc_dma_ff <= 1'b0;
            acc_addr_ff <= 8'h00;
            wdata_ff <= 8'h00;
            rdata_ff <= 8'h00;
        end else begin
            cs_prev_ff <= cs_act;
            if (bus_format_select_in && cs_start) begin
                addr_lat_ff <= dq_in;
            end
            acc_ff <= acc_on;
            if (acc_on) begin
                acc_wr_ff <= wr_act;
                acc_dma_ff <= dma_single_sel || dual_dma;
                acc_addr_ff <= eff_addr;
                wdata_ff <= dq_in;
                rdata_ff <= rd_mux;
            end
        end
    end

    // Software and status registers
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pld4_ff <= 2'h0;
            pld5_ff <= 1'b0;
            rxc4_ff <= 2'h0;
            rxc5_ff <= 1'b0;
        end else if (usb_reset_in) begin
            pld4_ff <= 2'h0;
            pld5_ff <= 1'b0;
            rxc4_ff <= 2'h0;
            rxc5_ff <= 1'b0;
        end else begin
            if (wr_commit && acc_addr_ff == `EHBP_ADDR_EP4_PLD) begin
                pld4_ff <= wdata_ff[1:0];
            end
            if (wr_commit && acc_addr_ff == `EHBP_ADDR_EP5_PLD) begin
                pld5_ff <= wdata_ff[0];
            end
            if (ep4_rx_load_in) begin
                rxc4_ff <= ep4_rx_count_in;
            end
            if (ep5_rx_load_in) begin
                rxc5_ff <= ep5_rx_count_in;
            end
        end
    end

    // Error flags: a new error wins over the start-of-packet clear
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            err_ff <= '0;
        end else if (usb_reset_in) begin
            err_ff <= '0;
        end else begin
            err_ff <= (sop_in ? '0 : err_ff) | pkt_err_in;
        end
    end

    // DMA request sequencer
    always_comb begin
        nxt_dma_st = dma_st_ff;
        nxt_gap_cnt = gap_cnt_ff;
        case (dma_st_ff)
            ehbp_pkg::EHBP_DMA_IDLE: begin
                if (more_data) begin
                    nxt_dma_st = ehbp_pkg::EHBP_DMA_REQ;
                end
            end
            ehbp_pkg::EHBP_DMA_REQ: begin
                if (dma_done && !dma_cfg_in.demand) begin
                    nxt_dma_st = ehbp_pkg::EHBP_DMA_GAP;
                    nxt_gap_cnt = REREQ_CYC + {1'b0, dma_cfg_in.interval} - 9'h001;
                end else if (!more_data) begin
                    nxt_dma_st = ehbp_pkg::EHBP_DMA_IDLE;
                end
            end
            ehbp_pkg::EHBP_DMA_GAP: begin
                if (gap_cnt_ff == 9'h000) begin
                    nxt_dma_st = more_data ? ehbp_pkg::EHBP_DMA_REQ
                        : ehbp_pkg::EHBP_DMA_IDLE;
                end else begin
                    nxt_gap_cnt = gap_cnt_ff - 9'h001;
                end
            end
            default: nxt_dma_st = ehbp_pkg::EHBP_DMA_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            dma_st_ff <= ehbp_pkg::EHBP_DMA_IDLE;
            gap_cnt_ff <= 9'h000;
        end else begin
            dma_st_ff <= nxt_dma_st;
            gap_cnt_ff <= nxt_gap_cnt;
        end
    end

    // Outputs
    assign dq_out = rdata_ff;
    assign dq_oe_out = acc_on && rd_act;
    assign ep4_payload_size_high_out = pld4_ff;
    assign ep5_payload_size_high_out = pld5_ff;
    assign fifo_rd_step_out = done_fifo && !acc_wr_ff;
    assign fifo_wr_step_out = done_fifo && acc_wr_ff;
    assign fifo_wdata_out = wdata_ff;
    assign fifo_clear_out = wr_commit && (acc_addr_ff == `EHBP_ADDR_FIFO_CLR);
    assign dma_request_out = (dma_st_ff == ehbp_pkg::EHBP_DMA_REQ);

    // Checks
    sequence s_single_done;
        dma_done && !dma_cfg_in.demand && dma_cfg_in.interval == 8'h00;
    endsequence
    sequence s_gap_refill;
        !dma_request_out && more_data;
    endsequence

    AST_EP4_UPPER_ZERO: assert property (@(posedge clk_in) disable iff (!rst_n)
        (acc_on && rd_act && eff_addr == `EHBP_ADDR_EP4_PLD) |=> rdata_ff[7:2] == 6'h00)
        else $error("ep4 payload upper bits not zero");
    AST_EP5_RX_UPPER_ZERO: assert property (@(posedge clk_in) disable iff (!rst_n)
        (acc_on && rd_act && eff_addr == `EHBP_ADDR_EP5_RXC) |=> rdata_ff[7:1] == 7'h00)
        else $error("ep5 count upper bits not zero");
    AST_BUS_RESET_CLEARS: assert property (@(posedge clk_in) disable iff (!rst_n)
        usb_reset_in |=> (pld4_ff == 2'h0 && !pld5_ff && rxc4_ff == 2'h0 && !rxc5_ff))
        else $error("bus reset left a register set");
    AST_PID_ERR_SET: assert property (@(posedge clk_in) disable iff (!rst_n)
        (pkt_err_in.pid && !usb_reset_in) |=> err_ff.pid)
        else $error("pid error flag not set");
    AST_SOP_CLEARS: assert property (@(posedge clk_in) disable iff (!rst_n)
        (sop_in && pkt_err_in == '0) |=> err_ff == '0)
        else $error("error flags not cleared by start of packet");
    AST_SINGLE_IGNORES_CS: assert property (@(posedge clk_in) disable iff (!rst_n)
        (dma_single_sel && rd_act)
        |=> (acc_ff && acc_dma_ff && acc_addr_ff == `EHBP_ADDR_FIFO))
        else $error("single address transfer not taken");
    AST_DUAL_IGNORES_DMA_ACKNOWLEDGE: assert property (@(posedge clk_in) disable iff (!rst_n)
        (dma_cfg_in.enable && !dma_cfg_in.single_addr && cs_act && rd_act
        && pin_addr == `EHBP_ADDR_FIFO)
        |=> (acc_ff && acc_dma_ff && acc_addr_ff == `EHBP_ADDR_FIFO))
        else $error("dual address transfer not taken");
    AST_STEP_ONCE: assert property (@(posedge clk_in) disable iff (!rst_n)
        (fifo_rd_step_out || fifo_wr_step_out) |=> !(fifo_rd_step_out || fifo_wr_step_out))
        else $error("fifo pointer stepped twice");
    AST_DEMAND_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n)
        (dma_request_out && dma_done && dma_cfg_in.demand && more_data) |=> dma_request_out)
        else $error("demand request dropped with data left");
    AST_SINGLE_REREQ: assert property (@(posedge clk_in) disable iff (!rst_n)
        (dma_request_out and s_single_done) |=> s_gap_refill |=> dma_request_out)
        else $error("single transfer request not re-raised in time");
    AST_MUX_LATCH: assert property (@(posedge clk_in) disable iff (!rst_n)
        (bus_format_select_in && cs_start) |=> addr_lat_ff == $past(dq_in))
        else $error("multiplexed address not latched");
endmodule
`default_nettype wire

// ---- dv/ehbp_host_model.sv ----
// Host model: local processor and DMA controller on the parallel bus
`default_nettype none
module ehbp_host_model (
    input wire logic clk_in,
    input wire logic mux_in,
    input wire logic [7:0] rdata_in,
    output logic cs_n_out,
    output logic rd_n_out,
    output logic wr_n_out,
    output logic ack_n_out,
    output logic [7:0] addr_out,
    output logic [7:0] dq_out
);
    timeunit 1ns;
    timeprecision 1ns;

    // Bus idles with every strobe released
    initial begin
        cs_n_out = 1'b1;
        rd_n_out = 1'b1;
        wr_n_out = 1'b1;
        ack_n_out = 1'b1;
        addr_out = 8'h00;
        dq_out = 8'h00;
    end

    // One access; mode 0 processor, 1 single-address DMA, 2 dual-address DMA
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        input int mode, input int gap, output logic [7:0] q);
        @(posedge clk_in);
        cs_n_out <= (mode == 1);
        ack_n_out <= (mode == 1) ? 1'b0 : ((mode == 2) ? 1'($urandom) : 1'b1);
        addr_out <= (mode == 1) ? ~a : a;
        dq_out <= mux_in ? a : ~a;
        @(posedge clk_in);
        rd_n_out <= wr;
        wr_n_out <= !wr;
        dq_out <= wr ? d : ~dq_out;
        repeat (3) @(posedge clk_in);
        q = rdata_in;
        cs_n_out <= 1'b1;
        rd_n_out <= 1'b1;
        wr_n_out <= 1'b1;
        ack_n_out <= 1'b1;
        dq_out <= ~dq_out;
        repeat (gap) @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench of the host bus port
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic usb_reset_in = 1'b0;
    logic bus_format_select_in = 1'b0;
    logic cs_n_in, rd_n_in, wr_n_in, dma_acknowledge_n_in;
    logic [7:0] addr_in, dq_in, dq_out, fifo_wdata_out;
    logic [7:0] fifo_rdata_in = 8'h00;
    logic dq_oe_out, fifo_rd_step_out, fifo_wr_step_out, fifo_clear_out, dma_request_out;
    ehbp_pkg::ehbp_err_t pkt_err_in = '0;
    ehbp_pkg::ehbp_dma_cfg_t dma_cfg_in = '0;
    logic sop_in = 1'b0;
    logic ep4_rx_load_in = 1'b0;
    logic ep5_rx_load_in = 1'b0;
    logic [1:0] ep4_rx_count_in = 2'h0;
    logic ep5_rx_count_in = 1'b0;
    logic fifo_has_data_in = 1'b0;
    logic [1:0] ep4_payload_size_high_out;
    logic ep5_payload_size_high_out;
    int n_mismatch = 0;
    int total_checks = 0;
    int n_rd = 0;
    int n_wr = 0;
    int n_clr = 0;
    int n_oe = 0;
    int cyc = 0;

    ehbp_port i_dut (.clk_in, .nrst_in, .usb_reset_in, .bus_format_select_in, .cs_n_in,
        .rd_n_in, .wr_n_in, .addr_in, .dq_in, .dq_out, .dq_oe_out, .pkt_err_in, .sop_in,
        .ep4_rx_load_in, .ep4_rx_count_in, .ep5_rx_load_in, .ep5_rx_count_in,
        .ep4_payload_size_high_out, .ep5_payload_size_high_out, .fifo_rdata_in,
        .fifo_has_data_in, .fifo_rd_step_out, .fifo_wr_step_out, .fifo_wdata_out,
        .fifo_clear_out, .dma_cfg_in, .dma_acknowledge_n_in, .dma_request_out);

    ehbp_host_model i_host (.clk_in, .mux_in(bus_format_select_in), .rdata_in(dq_out),
        .cs_n_out(cs_n_in), .rd_n_out(rd_n_in), .wr_n_out(wr_n_in),
        .ack_n_out(dma_acknowledge_n_in), .addr_out(addr_in), .dq_out(dq_in));

    // Clock of 50 ns period
    always #25 clk_in = ~clk_in;

    // Pulse counters and the hang limit
    always @(posedge clk_in) begin
        cyc++;
        n_rd += (fifo_rd_step_out === 1'b1);
        n_wr += (fifo_wr_step_out === 1'b1);
        n_clr += (fifo_clear_out === 1'b1);
        n_oe += (dq_oe_out === 1'b1);
        if (cyc > 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    // Expected read-back of a narrow register
    function automatic logic [7:0] narrow(input logic [7:0] a, input logic [7:0] v);
        return a[0] ? {7'h00, v[0]} : {6'h00, v[1:0]};
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        i_host.xfer(1'b0, a, 8'h00, 0, 3, q);
    endtask

    task automatic wait_req();
        for (int i = 0; i < 20 && dma_request_out !== 1'b1; i++) @(posedge clk_in);
        chk({7'h00, dma_request_out}, 8'h01);
    endtask

    task automatic print_verdict();
        if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Main sequence
    initial begin
        logic [7:0] q, v, a;
        int base, lo;
        logic [7:0] regs [6] = '{8'h39, 8'h6C, 8'h6D, 8'h74, 8'h75, 8'h13};
        v = 8'($urandom(69));
        repeat (10) @(posedge clk_in);
        nrst_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        foreach (regs[i]) begin
            lo = n_oe;
            rd(regs[i], q);
            chk(q, 8'h00);
            chk(8'(n_oe - lo), 8'h03);
        end
        for (int f = 0; f < 2; f++) begin
            bus_format_select_in <= f[0];
            for (int k = 0; k < 8; k++) begin
                a = 8'h6C + 8'(k % 2);
                v = 8'($urandom);
                i_host.xfer(1'b1, a, v, 0, 3, q);
                q = {6'h00, ep4_payload_size_high_out};
                if (k[0]) q = {7'h00, ep5_payload_size_high_out};
                chk(q, narrow(a, v));
                rd(a, q);
                chk(q, narrow(a, v));
            end
        end
        v = 8'($urandom);
        @(posedge clk_in);
        {ep5_rx_count_in, ep4_rx_count_in} <= v[2:0];
        {ep4_rx_load_in, ep5_rx_load_in} <= 2'h3;
        @(posedge clk_in);
        {ep4_rx_load_in, ep5_rx_load_in} <= 2'h0;
        i_host.xfer(1'b1, 8'h74, 8'hFF, 0, 3, q);
        rd(8'h74, q);
        chk(q, narrow(8'h74, v));
        rd(8'h75, q);
        chk(q, narrow(8'h75, {7'h00, v[2]}));
        for (int b = 0; b < 4; b++) begin
            @(posedge clk_in) pkt_err_in <= ehbp_pkg::ehbp_err_t'(4'h1 << b);
            @(posedge clk_in) pkt_err_in <= '0;
            rd(8'h39, q);
            chk(q, 8'h01 << b);
            @(posedge clk_in) sop_in <= 1'b1;
            @(posedge clk_in) sop_in <= 1'b0;
            rd(8'h39, q);
            chk(q, 8'h00);
        end
        i_host.xfer(1'b1, 8'h6C, 8'hFF, 0, 3, q);
        @(posedge clk_in) usb_reset_in <= 1'b1;
        @(posedge clk_in) usb_reset_in <= 1'b0;
        rd(8'h6C, q);
        chk(q, 8'h00);
        rd(8'h74, q);
        chk(q, 8'h00);
        i_host.xfer(1'b1, 8'h6D, 8'hFF, 0, 3, q);
        rd(8'h6D, q);
        chk(q, 8'h01);
        nrst_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        nrst_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        rd(8'h6D, q);
        chk(q, 8'h00);
        base = n_wr;
        for (int k = 0; k < 4; k++) begin
            v = 8'($urandom);
            i_host.xfer(1'b1, 8'h40, v, 0, 3, q);
            chk(fifo_wdata_out, v);
            fifo_rdata_in <= ~v;
            rd(8'h40, q);
            chk(q, ~v);
        end
        chk(8'(n_wr - base), 8'h04);
        chk(8'(n_rd), 8'h04);
        i_host.xfer(1'b1, 8'h4E, 8'h01, 0, 3, q);
        chk(8'(n_clr), 8'h01);
        fifo_has_data_in <= 1'b1;
        for (int iv = 0; iv < 3; iv++) begin
            dma_cfg_in <= '{1'b1, 1'b1, 1'b0, 8'(iv)};
            wait_req();
            base = n_rd;
            lo = 0;
            i_host.xfer(1'b0, 8'h40, 8'h00, 1, 0, q);
            repeat (20) @(posedge clk_in) lo += (dma_request_out === 1'b0);
            chk(8'(n_rd - base), 8'h01);
            chk(8'(lo), 8'(1 + iv));
        end
        dma_cfg_in <= '{1'b1, 1'b0, 1'b0, 8'h00};
        wait_req();
        base = n_rd;
        i_host.xfer(1'b0, 8'h40, 8'h00, 2, 5, q);
        lo = n_oe;
        i_host.xfer(1'b0, 8'h40, 8'h00, 1, 5, q);
        chk(8'(n_rd - base), 8'h01);
        chk(8'(n_oe - lo), 8'h00);
        dma_cfg_in <= '{1'b1, 1'b1, 1'b1, 8'h00};
        wait_req();
        repeat (2) begin
            i_host.xfer(1'b0, 8'h40, 8'h00, 1, 3, q);
            chk({7'h00, dma_request_out}, 8'h01);
        end
        base = n_wr;
        v = 8'($urandom);
        i_host.xfer(1'b1, 8'h40, v, 1, 3, q);
        chk(8'(n_wr - base), 8'h01);
        chk(fifo_wdata_out, v);
        chk({7'h00, dma_request_out}, 8'h01);
        fifo_has_data_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        chk({7'h00, dma_request_out}, 8'h00);
        print_verdict();
    end
endmodule
`default_nettype wire
